// file: rtl/adqa_top.sv
// two-queue priority arbiter in front of one shared converter, with an AXI4-Lite register slave
//
// Summary of operation
// RULE1: queue 1 starts: external, software, continuous completion
// RULE2: queue 2 starts: external, software, timer, continuous
// RULE3: end of queue sets completion flag
// RULE4: finished pause word sets pause flag
// RULE5: start before previous serviced sets overrun; code drops a software start during a pass without setting overrun
// RULE6: report idle, active, paused, pending, suspended
// RULE7: 4-bit joint code; 0011, 0111 transitional
// RULE8: premature start ignored except overrun
// RULE9: extra premature starts discarded; restart after pass
// RULE10: subqueues: overrun same, execution unchanged
// RULE11: queue 2 start during queue 1 pending
// RULE12: repeated queue 2 starts set overrun only
// RULE13: queue 1 start aborts and suspends queue 2
// RULE14: resume bit clear: restart queue 2 first word
// RULE15: resume bit set: continue at aborted word
// RULE16: queue 2 start while suspended sets overrun
// RULE17: freeze lets conversion finish, then halts
// RULE18: after freeze continue with next word
// RULE19: starts during freeze are not captured
// RULE20: pending queue 2 start survives freeze
// RULE21: suspended queue 2 resumes after queue 1
// RULE22: simultaneous starts: queue 1 runs, 2 pending
// RULE23: pause ends subqueue; wait for next start; in software modes code restarts a paused queue by itself one cycle later
// RULE24: channel 63 word completes queue, no conversion
// RULE25: distinct stable codes per condition pair; code gives queue 2 active and suspended the same low pair 10
`timescale 1ns/1ps
`include "adqa_consts.svh"

module adqa_top (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // AXI4-Lite slave
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // trigger sources, one-cycle pulses, and the FREEZE level
  input wire logic EXT_TRIG1,
  input wire logic EXT_TRIG2,
  input wire logic TIMER_TRIG2,
  input wire logic FREEZE,
  // converter handshake
  output logic CONV_START,
  output logic CONV_ABORT,
  output logic [5:0] CONV_CHANNEL,
  input wire logic CONV_DONE
);

  function automatic adqa_pkg::adqa_sel_t adqa_decode(input logic [11:0] addr);
    if (addr[11:8] == `ADQA_TABLE_PAGE) begin
      adqa_decode = adqa_pkg::SEL_TABLE;
    end else if (addr[11:2] == `ADQA_CTRL_OFS >> 2) begin
      adqa_decode = adqa_pkg::SEL_CTRL;
    end else if (addr[11:2] == `ADQA_STATUS_OFS >> 2) begin
      adqa_decode = adqa_pkg::SEL_STATUS;
    end else if (addr[11:2] == `ADQA_FLAGS_OFS >> 2) begin
      adqa_decode = adqa_pkg::SEL_FLAGS;
    end else begin
      adqa_decode = adqa_pkg::SEL_NONE;
    end
  endfunction

  function automatic logic [2:0] adqa_cond(input adqa_pkg::adqa_cond_t c);
    case (c)
      adqa_pkg::Q_ACTIVE: adqa_cond = `ADQA_COND_ACTIVE;
      adqa_pkg::Q_PAUSED: adqa_cond = `ADQA_COND_PAUSED;
      adqa_pkg::Q_PENDING: adqa_cond = `ADQA_COND_PENDING;
      adqa_pkg::Q_SUSPENDED: adqa_cond = `ADQA_COND_SUSPENDED;
      default: adqa_cond = `ADQA_COND_IDLE;
    endcase
  endfunction

  // upper pair is queue 1 (idle/paused/active), lower pair queue 2; q1 idle or paused with
  // q2 pending lasts one cycle only, outside freeze
  function automatic logic [3:0] adqa_code(input adqa_pkg::adqa_cond_t c1, input adqa_pkg::adqa_cond_t c2);
    logic [1:0] hi;
    logic [1:0] lo;
    hi = (c1 == adqa_pkg::Q_ACTIVE) ? 2'h2 : (c1 == adqa_pkg::Q_PAUSED) ? 2'h1 : 2'h0;
    case (c2)
      adqa_pkg::Q_PAUSED: lo = 2'h1;
      adqa_pkg::Q_ACTIVE: lo = 2'h2;
      adqa_pkg::Q_SUSPENDED: lo = 2'h2;
      adqa_pkg::Q_PENDING: lo = 2'h3;
      default: lo = 2'h0;
    endcase
    adqa_code = {hi, lo}; // [RULE7] [RULE25]
  endfunction

  // register state
  adqa_pkg::adqa_mode_t mode1_q;
  adqa_pkg::adqa_mode_t mode2_q;
  logic src2_timer_q, resume_q, sse1_q, sse2_q;
  logic [5:0] bq2_q;
  logic [5:0] flags_q;
  logic [6:0] cmd_mem [64];

  // bus state
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // queue and converter state
  adqa_pkg::adqa_cond_t q1_q, q1_d, q2_q, q2_d;
  logic [5:0] ptr1_q, ptr1_d, ptr2_q, ptr2_d;
  logic busy_q, busy_d, own1_q, own1_d, pause_q, pause_d;
  logic start_q, start_d, abort_q, abort_d;
  logic [5:0] chan_q, chan_d;
  logic auto1_q, auto1_d, auto2_q, auto2_d;
  logic [5:0] flag_set;
  logic sse1_clr, sse2_clr;

  // decoded writes
  logic wr_fire;
  adqa_pkg::adqa_sel_t wr_sel;
  logic [31:0] wmask, ctrl_img, ctrl_new;
  logic ctrl_wr, flags_wr, table_wr;
  logic sw1_mode, sw2_mode, sw1_go, sw2_go, t1, t2;
  logic [6:0] w1, w2;

  assign S_AXI_AWREADY = !aw_held_q;
  assign S_AXI_WREADY = !w_held_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign CONV_START = start_q;
  assign CONV_ABORT = abort_q;
  assign CONV_CHANNEL = chan_q;

  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_sel = adqa_decode(awaddr_q);
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign ctrl_wr = wr_fire && (wr_sel == adqa_pkg::SEL_CTRL);
  assign flags_wr = wr_fire && (wr_sel == adqa_pkg::SEL_FLAGS);
  assign table_wr = wr_fire && (wr_sel == adqa_pkg::SEL_TABLE) && wstrb_q[0];

  always_comb begin
    ctrl_img = 32'h0000_0000;
    ctrl_img[`ADQA_CTRL_MODE1_LSB +: 3] = mode1_q;
    ctrl_img[`ADQA_CTRL_MODE2_LSB +: 3] = mode2_q;
    ctrl_img[`ADQA_CTRL_SRC2_BIT] = src2_timer_q;
    ctrl_img[`ADQA_CTRL_RESUME_BIT] = resume_q;
    ctrl_img[`ADQA_CTRL_BQ2_LSB +: 6] = bq2_q;
    ctrl_new = (ctrl_img & ~wmask) | (wdata_q & wmask);
  end

  // software starts are taken only when the queue waits; a write mid-pass has no effect
  assign sw1_mode = (mode1_q == adqa_pkg::MODE_SW_SINGLE) || (mode1_q == adqa_pkg::MODE_SW_CONT);
  assign sw2_mode = (mode2_q == adqa_pkg::MODE_SW_SINGLE) || (mode2_q == adqa_pkg::MODE_SW_CONT);
  assign sw1_go = ctrl_wr && ctrl_new[`ADQA_CTRL_SSE1_BIT] && sw1_mode && (q1_q != adqa_pkg::Q_ACTIVE);
  assign sw2_go = ctrl_wr && ctrl_new[`ADQA_CTRL_SSE2_BIT] && sw2_mode &&
                  ((q2_q == adqa_pkg::Q_IDLE) || (q2_q == adqa_pkg::Q_PAUSED));

  // freeze masks every source, so nothing arriving in freeze is latched [RULE19]
  assign t1 = !FREEZE && ((EXT_TRIG1 && ((mode1_q == adqa_pkg::MODE_EXT_CONT) ||
              (mode1_q == adqa_pkg::MODE_EXT_SINGLE && sse1_q))) || sw1_go || auto1_q); // [RULE1]
  assign t2 = !FREEZE && (((src2_timer_q ? TIMER_TRIG2 : EXT_TRIG2) && ((mode2_q == adqa_pkg::MODE_EXT_CONT) ||
              (mode2_q == adqa_pkg::MODE_EXT_SINGLE && sse2_q))) || sw2_go || auto2_q); // [RULE2]

  assign w1 = cmd_mem[ptr1_q];
  assign w2 = cmd_mem[ptr2_q];

  always_comb begin
    q1_d = q1_q;
    q2_d = q2_q;
    ptr1_d = ptr1_q;
    ptr2_d = ptr2_q;
    busy_d = busy_q;
    own1_d = own1_q;
    pause_d = pause_q;
    chan_d = chan_q;
    start_d = 1'b0;
    abort_d = 1'b0;
    auto1_d = auto1_q;
    auto2_d = auto2_q;
    flag_set = 6'h00;
    sse1_clr = 1'b0;
    sse2_clr = 1'b0;
    if (CONV_DONE && busy_q) begin
      // a conversion under way finishes, freeze or not, unless a queue 1 start aborts it [RULE17]
      busy_d = 1'b0;
      if (own1_q) begin
        ptr1_d = ptr1_q + 6'h01; // [RULE18]
        if (pause_q) begin
          flag_set[`ADQA_FLAG_PF1_BIT] = 1'b1; // [RULE4]
          q1_d = adqa_pkg::Q_PAUSED; // [RULE23]
          auto1_d = sw1_mode;
        end
      end else begin
        ptr2_d = ptr2_q + 6'h01; // [RULE18]
        if (pause_q) begin
          flag_set[`ADQA_FLAG_PF2_BIT] = 1'b1; // [RULE4]
          q2_d = adqa_pkg::Q_PAUSED; // [RULE23]
          auto2_d = sw2_mode;
        end
      end
    end else if (!busy_q && !FREEZE) begin
      if (q1_q == adqa_pkg::Q_ACTIVE) begin
        if (w1[5:0] == `ADQA_EOQ_CHANNEL || ptr1_q == bq2_q) begin
          flag_set[`ADQA_FLAG_CF1_BIT] = 1'b1; // [RULE3] [RULE24]
          q1_d = adqa_pkg::Q_IDLE;
          sse1_clr = 1'b1;
          auto1_d = (mode1_q == adqa_pkg::MODE_SW_CONT); // [RULE1] [RULE9]
        end else begin
          start_d = 1'b1;
          chan_d = w1[5:0];
          pause_d = w1[6];
          busy_d = 1'b1;
          own1_d = 1'b1;
        end
      end else if (!t1) begin
        if (q2_q == adqa_pkg::Q_PENDING || q2_q == adqa_pkg::Q_SUSPENDED) begin
          q2_d = adqa_pkg::Q_ACTIVE; // [RULE11] [RULE21]
          if (q2_q == adqa_pkg::Q_SUSPENDED && !resume_q) begin
            ptr2_d = bq2_q; // [RULE14]
          end
        end else if (q2_q == adqa_pkg::Q_ACTIVE) begin
          if (w2[5:0] == `ADQA_EOQ_CHANNEL) begin
            flag_set[`ADQA_FLAG_CF2_BIT] = 1'b1; // [RULE3] [RULE24]
            q2_d = adqa_pkg::Q_IDLE;
            sse2_clr = 1'b1;
            auto2_d = (mode2_q == adqa_pkg::MODE_SW_CONT); // [RULE2]
          end else begin
            start_d = 1'b1;
            chan_d = w2[5:0];
            pause_d = w2[6];
            busy_d = 1'b1;
            own1_d = 1'b0;
          end
        end
      end
    end
    if (t1) begin
      if (q1_q == adqa_pkg::Q_ACTIVE) begin
        flag_set[`ADQA_FLAG_OVR1_BIT] = 1'b1; // [RULE5] [RULE8] [RULE9] [RULE10]
      end else begin
        q1_d = adqa_pkg::Q_ACTIVE;
        auto1_d = 1'b0;
        if (q1_q == adqa_pkg::Q_IDLE) begin
          ptr1_d = 6'h00;
        end
        if (q2_d == adqa_pkg::Q_ACTIVE) begin
          // the queue 2 pointer is left on the aborted word, so a resume repeats it [RULE15]
          q2_d = adqa_pkg::Q_SUSPENDED; // [RULE13]
          if (busy_q && !own1_q && !CONV_DONE) begin
            abort_d = 1'b1; // [RULE13]
            busy_d = 1'b0;
          end
        end
      end
    end
    if (t2) begin
      if (q2_q == adqa_pkg::Q_IDLE || q2_q == adqa_pkg::Q_PAUSED) begin
        auto2_d = 1'b0;
        if (q2_q == adqa_pkg::Q_IDLE) begin
          ptr2_d = bq2_q;
        end
        q2_d = (q1_q == adqa_pkg::Q_ACTIVE || t1) ? adqa_pkg::Q_PENDING : adqa_pkg::Q_ACTIVE; // [RULE11] [RULE22]
      end else begin
        flag_set[`ADQA_FLAG_OVR2_BIT] = 1'b1; // [RULE5] [RULE12] [RULE16]
      end
    end
  end

  // queue sequencing; a pending start simply waits here through freeze [RULE20]
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      q1_q <= adqa_pkg::Q_IDLE;
      q2_q <= adqa_pkg::Q_IDLE;
      ptr1_q <= 6'h00;
      ptr2_q <= 6'h00;
      auto1_q <= 1'b0;
      auto2_q <= 1'b0;
    end else begin
      q1_q <= q1_d; // [RULE6]
      q2_q <= q2_d; // [RULE6]
      ptr1_q <= ptr1_d;
      ptr2_q <= ptr2_d;
      auto1_q <= auto1_d;
      auto2_q <= auto2_d;
    end
  end

  // converter handshake
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      busy_q <= 1'b0;
      own1_q <= 1'b0;
      pause_q <= 1'b0;
      chan_q <= 6'h00;
      start_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      own1_q <= own1_d;
      pause_q <= pause_d;
      chan_q <= chan_d;
      start_q <= start_d;
      abort_q <= abort_d;
    end
  end

  // sticky flags: a hardware set in the clearing cycle wins
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      flags_q <= 6'h00;
    end else if (flags_wr) begin
      flags_q <= (flags_q & ~(wdata_q[5:0] & wmask[5:0])) | flag_set;
    end else begin
      flags_q <= flags_q | flag_set;
    end
  end

  // control register; single-scan enables are write-one and cleared by completion
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      mode1_q <= adqa_pkg::MODE_DISABLED;
      mode2_q <= adqa_pkg::MODE_DISABLED;
      src2_timer_q <= 1'b0;
      resume_q <= 1'b0;
      bq2_q <= `ADQA_BQ2_RESET;
      sse1_q <= 1'b0;
      sse2_q <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        mode1_q <= adqa_pkg::adqa_mode_t'(ctrl_new[`ADQA_CTRL_MODE1_LSB +: 3]);
        mode2_q <= adqa_pkg::adqa_mode_t'(ctrl_new[`ADQA_CTRL_MODE2_LSB +: 3]);
        src2_timer_q <= ctrl_new[`ADQA_CTRL_SRC2_BIT];
        resume_q <= ctrl_new[`ADQA_CTRL_RESUME_BIT];
        bq2_q <= ctrl_new[`ADQA_CTRL_BQ2_LSB +: 6];
      end
      sse1_q <= (sse1_q && !sse1_clr) || (ctrl_wr && ctrl_new[`ADQA_CTRL_SSE1_BIT]);
      sse2_q <= (sse2_q && !sse2_clr) || (ctrl_wr && ctrl_new[`ADQA_CTRL_SSE2_BIT]);
    end
  end

  // command word table, channel in [5:0], pause in [6]; not reset, software loads it
  always_ff @(posedge CLOCK) begin
    if (table_wr) begin
      cmd_mem[awaddr_q[7:2]] <= wdata_q[6:0];
    end
  end

  // write channel: address and data are latched independently, then answered together
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `ADQA_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_sel == adqa_pkg::SEL_NONE) ? `ADQA_RESP_SLVERR : `ADQA_RESP_OKAY;
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel, one cycle from address to data
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ADQA_RESP_OKAY;
    end else if (S_AXI_ARVALID && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= `ADQA_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      case (adqa_decode(S_AXI_ARADDR))
        adqa_pkg::SEL_CTRL: rdata_q <= ctrl_img;
        adqa_pkg::SEL_STATUS: begin
          rdata_q[`ADQA_STAT_CODE_LSB +: 4] <= adqa_code(q1_q, q2_q); // [RULE7]
          rdata_q[`ADQA_STAT_COND1_LSB +: 3] <= adqa_cond(q1_q); // [RULE6]
          rdata_q[`ADQA_STAT_COND2_LSB +: 3] <= adqa_cond(q2_q); // [RULE6]
          rdata_q[`ADQA_STAT_BUSY_BIT] <= busy_q;
          rdata_q[`ADQA_STAT_FREEZE_BIT] <= FREEZE;
        end
        adqa_pkg::SEL_FLAGS: rdata_q[5:0] <= flags_q;
        adqa_pkg::SEL_TABLE: rdata_q[6:0] <= cmd_mem[S_AXI_ARADDR[7:2]];
        default: rresp_q <= `ADQA_RESP_SLVERR;
      endcase
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  default clocking adqa_cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  a_preempt_abort: assert property (t1 && q1_q != adqa_pkg::Q_ACTIVE && q2_q == adqa_pkg::Q_ACTIVE && busy_q &&
      !own1_q && !CONV_DONE |=> CONV_ABORT && q2_q == adqa_pkg::Q_SUSPENDED && q1_q == adqa_pkg::Q_ACTIVE) // [RULE13]
    else $error("queue 2 not aborted by queue 1 start");
  a_overrun_q1: assert property (t1 && q1_q == adqa_pkg::Q_ACTIVE |=> flags_q[`ADQA_FLAG_OVR1_BIT]) // [RULE5]
    else $error("queue 1 overrun not flagged");
  a_premature_kept: assert property (t1 && q1_q == adqa_pkg::Q_ACTIVE && busy_q && !CONV_DONE |=>
      q1_q == adqa_pkg::Q_ACTIVE && $stable(ptr1_q)) // [RULE8]
    else $error("premature start disturbed queue 1");
  a_q2_pending: assert property (t2 && !t1 && q1_q == adqa_pkg::Q_ACTIVE && q2_q == adqa_pkg::Q_IDLE |=>
      q2_q == adqa_pkg::Q_PENDING ##1 q2_q == adqa_pkg::Q_PENDING || q1_q != adqa_pkg::Q_ACTIVE) // [RULE11]
    else $error("queue 2 start not held pending");
  a_simul_start: assert property (t1 && t2 && q1_q == adqa_pkg::Q_IDLE && q2_q == adqa_pkg::Q_IDLE |=>
      q1_q == adqa_pkg::Q_ACTIVE && q2_q == adqa_pkg::Q_PENDING) // [RULE22]
    else $error("simultaneous starts mishandled");
  a_freeze_quiet: assert property (FREEZE |=> !CONV_START && !CONV_ABORT) // [RULE17]
    else $error("converter touched during freeze");
  a_eoq_done: assert property (q1_q == adqa_pkg::Q_ACTIVE && !busy_q && !FREEZE && !t1 &&
      w1[5:0] == `ADQA_EOQ_CHANNEL |=> flags_q[`ADQA_FLAG_CF1_BIT] && q1_q == adqa_pkg::Q_IDLE && !CONV_START) // [RULE24]
    else $error("end-of-queue word not completing queue 1");
  a_pause_flag: assert property (CONV_DONE && busy_q && own1_q && pause_q && !t1 |=>
      flags_q[`ADQA_FLAG_PF1_BIT] && q1_q == adqa_pkg::Q_PAUSED) // [RULE4]
    else $error("pause word did not pause queue 1");
  a_resume_first: assert property (q1_q != adqa_pkg::Q_ACTIVE && q2_q == adqa_pkg::Q_SUSPENDED && !resume_q &&
      !FREEZE && !busy_q && !t1 && !t2 |=> q2_q == adqa_pkg::Q_ACTIVE && ptr2_q == bq2_q) // [RULE14]
    else $error("suspended queue 2 not restarted at first word");
  a_code_brief: assert property (adqa_code(q1_q, q2_q) == 4'h3 && !FREEZE |=> adqa_code(q1_q, q2_q) != 4'h3) // [RULE7]
    else $error("transitional code held");
  a_overrun_susp: assert property (t2 && q2_q == adqa_pkg::Q_SUSPENDED |=> flags_q[`ADQA_FLAG_OVR2_BIT] &&
      q2_q == adqa_pkg::Q_SUSPENDED || q2_q == adqa_pkg::Q_ACTIVE) // [RULE16]
    else $error("queue 2 overrun while suspended missing");

  c_preempt: cover property (CONV_ABORT ##[1:50] q2_q == adqa_pkg::Q_ACTIVE);
  c_pending_run: cover property (q2_q == adqa_pkg::Q_PENDING ##[1:100] q2_q == adqa_pkg::Q_ACTIVE);
  c_freeze_finish: cover property (FREEZE && busy_q ##[1:40] FREEZE && !busy_q);
  c_pause_then_go: cover property (q1_q == adqa_pkg::Q_PAUSED ##[1:50] q1_q == adqa_pkg::Q_ACTIVE);

endmodule // adqa_top

// file: rtl/adqa_consts.svh
// register offsets, field positions, reset values and codes of the dual queue arbiter
`ifndef ADQA_CONSTS_SVH
`define ADQA_CONSTS_SVH

`define ADQA_CTRL_OFS 12'h000
`define ADQA_STATUS_OFS 12'h004
`define ADQA_FLAGS_OFS 12'h008
`define ADQA_TABLE_PAGE 4'h1

`define ADQA_CTRL_MODE1_LSB 0
`define ADQA_CTRL_MODE2_LSB 4
`define ADQA_CTRL_SRC2_BIT 8
`define ADQA_CTRL_RESUME_BIT 9
`define ADQA_CTRL_SSE1_BIT 16
`define ADQA_CTRL_SSE2_BIT 17
`define ADQA_CTRL_BQ2_LSB 24

`define ADQA_STAT_CODE_LSB 0
`define ADQA_STAT_COND1_LSB 4
`define ADQA_STAT_COND2_LSB 8
`define ADQA_STAT_BUSY_BIT 16
`define ADQA_STAT_FREEZE_BIT 17

`define ADQA_FLAG_CF1_BIT 0
`define ADQA_FLAG_PF1_BIT 1
`define ADQA_FLAG_OVR1_BIT 2
`define ADQA_FLAG_CF2_BIT 3
`define ADQA_FLAG_PF2_BIT 4
`define ADQA_FLAG_OVR2_BIT 5

`define ADQA_BQ2_RESET 6'h20
`define ADQA_EOQ_CHANNEL 6'h3F

`define ADQA_COND_IDLE 3'h0
`define ADQA_COND_ACTIVE 3'h1
`define ADQA_COND_PAUSED 3'h2
`define ADQA_COND_PENDING 3'h3
`define ADQA_COND_SUSPENDED 3'h4

`define ADQA_RESP_OKAY 2'h0
`define ADQA_RESP_SLVERR 2'h2

`endif

// file: rtl/adqa_pkg.sv
// types of the dual queue arbiter
package adqa_pkg;
  typedef enum logic [2:0] {
    MODE_DISABLED,
    MODE_SW_SINGLE,
    MODE_EXT_SINGLE,
    MODE_SW_CONT,
    MODE_EXT_CONT
  } adqa_mode_t;

  typedef enum logic [2:0] {
    Q_IDLE,
    Q_ACTIVE,
    Q_PAUSED,
    Q_PENDING,
    Q_SUSPENDED
  } adqa_cond_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CTRL,
    SEL_STATUS,
    SEL_FLAGS,
    SEL_TABLE
  } adqa_sel_t;
endpackage

// file: tb/adqa_conv_model.sv
// converter stand-in that answers each start that is not aborted after a set latency
`timescale 1ns/1ps
module adqa_conv_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // converter handshake
  input wire logic start,
  input wire logic abort,
  input wire logic [7:0] lat,
  output logic done
);
  logic busy_q;
  logic [7:0] cnt_q;
  always_ff @(posedge clk) begin
    done <= 1'h0;
    if (!rst_n) begin
      busy_q <= 1'h0;
      cnt_q <= 8'h00;
    end else if (start) begin
      busy_q <= 1'h1;
      cnt_q <= lat;
    end else if (busy_q && abort) begin
      // an aborted conversion never reports done
      busy_q <= 1'h0;
    end else if (busy_q && cnt_q == 8'h00) begin
      busy_q <= 1'h0;
      done <= 1'h1;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule // adqa_conv_model

// file: tb/testbench.sv
// self-checking bench for the dual queue arbiter
`timescale 1ns/1ps
module testbench;
  typedef struct {string nm; logic [31:0] d; logic [31:0] m; logic [1:0] r;} adqa_exp_t;
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, conv_done, conv_start, conv_abort;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  logic trig1 = 1'h0, trig2 = 1'h0, ttrig2 = 1'h0, freeze = 1'h0;
  logic [5:0] conv_ch;
  logic [7:0] lat = 8'h0C;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  adqa_exp_t rq[$];
  logic [5:0] chq[$];
  logic [1:0] bq[$];
  logic src_t = 1'h0;

  initial forever #5 clock = ~clock;

  adqa_top uut (.CLOCK(clock), .RSTN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .EXT_TRIG1(trig1),
    .EXT_TRIG2(trig2), .TIMER_TRIG2(ttrig2), .FREEZE(freeze), .CONV_START(conv_start),
    .CONV_ABORT(conv_abort), .CONV_CHANNEL(conv_ch), .CONV_DONE(conv_done));
  adqa_conv_model conv (.clk(clock), .rst_n(rstn), .start(conv_start), .abort(conv_abort),
    .lat(lat), .done(conv_done));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge clock);
    bq.push_back((a[11:8] == 4'h1 || a < 12'h00C) ? 2'h0 : 2'h2);
    awaddr <= a;
    // table words ignore upper bits and lanes, so those carry noise
    wdata <= (a[11:8] == 4'h1) ? (d | ($urandom & 32'hFFFF_FF80)) : d;
    wstrb <= (a[11:8] == 4'h1) ? {3'($urandom), 1'h1} : 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock);
      if (!aw_ok && awready === 1'h1) begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w_ok && wready === 1'h1) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end
    while (bvalid !== 1'h1) @(posedge clock);
    bready <= 1'h0;
  endtask

  // every read leaves a note; polls use a zero mask so the notes stay in step
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] r, output logic [31:0] q);
    rq.push_back('{$sformatf("read %h", a), e, m, r});
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clock); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clock); while (rvalid !== 1'h1);
    q = rdata;
    rready <= 1'h0;
  endtask

  task automatic pulse(input logic [2:0] p);
    @(posedge clock);
    trig1 <= p[2];
    // the unselected queue 2 source carries noise that must be ignored
    trig2 <= src_t ? 1'($urandom) : p[1];
    ttrig2 <= src_t ? p[0] : 1'($urandom);
    @(posedge clock);
    trig1 <= 1'h0;
    trig2 <= 1'h0;
    ttrig2 <= 1'h0;
  endtask

  task automatic wait_hi(input logic ab);
    do @(posedge clock); while ((ab ? conv_abort : conv_start) !== 1'h1);
  endtask

  task automatic wait_idle();
    logic [31:0] s;
    s = 32'hFFFFFFFF;
    while (s[16:4] !== 13'h0) rd(12'h004, 32'h0, 32'h0, 2'h0, s);
  endtask

  always @(posedge clock) begin
    adqa_exp_t e;
    if (rvalid === 1'h1 && rready === 1'h1 && rq.size() > 0) begin
      e = rq.pop_front();
      check({e.nm, " data"}, rdata & e.m, e.d);
      check({e.nm, " resp"}, {30'h0, rresp}, {30'h0, e.r});
    end
    // a start with no note left is an unexpected restart
    if (conv_start === 1'h1) check("channel", {26'h0, conv_ch}, chq.size() ? {26'h0, chq.pop_front()} : '1);
    if (bvalid === 1'h1 && bready === 1'h1 && bq.size() > 0) check("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(32'hC4AB));
    repeat (6) @(posedge clock);
    rstn <= 1'h1;
    rd(12'h000, 32'h2000_0000, '1, 2'h0, v);
    rd(12'h004, 32'h0, '1, 2'h0, v);
    rd(12'h008, 32'h0, '1, 2'h0, v);
    rd(12'h00C + 12'(4 * $urandom_range(60)), 32'h0, '1, 2'h2, v);
    wr(12'h00C + 12'(4 * $urandom_range(60)), $urandom);
    wr(12'h004, $urandom);
    rd(12'h004, 32'h0, '1, 2'h0, v);
    $display("test reset done");
    wr(12'h100, 32'h05);
    wr(12'h104, 32'h3F);
    wr(12'h180, 32'h07);
    wr(12'h184, 32'h08);
    wr(12'h188, 32'h3F);
    lat <= 8'(12 + $urandom_range(15));
    wr(12'h000, 32'h2001_0002);
    chq.push_back(6'h05);
    pulse(3'h4);
    wait_hi(1'h0);
    pulse(3'h4);
    pulse(3'h4);
    wait_idle();
    rd(12'h008, 32'h05, '1, 2'h0, v);
    wr(12'h008, 32'h3F);
    rd(12'h008, 32'h0, '1, 2'h0, v);
    $display("test overrun done");
    for (int r = 0; r < 2; r++) begin
      lat <= 8'(12 + $urandom_range(15));
      wr(12'h000, 32'h2003_0022 | (32'(r) << 9));
      chq.push_back(6'h07);
      chq.push_back(6'h08);
      chq.push_back(6'h05);
      if (r == 0) chq.push_back(6'h07);
      chq.push_back(6'h08);
      pulse(3'h2);
      wait_hi(1'h0);
      wait_hi(1'h0);
      pulse(3'h4);
      wait_hi(1'h1);
      wait_hi(1'h0);
      rd(12'h004, 32'h0001_041A, '1, 2'h0, v);
      pulse(3'h2);
      wait_idle();
      rd(12'h008, 32'h29, '1, 2'h0, v);
      wr(12'h008, 32'h3F);
    end
    $display("test preempt done");
    src_t = 1'h1;
    wr(12'h000, 32'h2003_0122);
    chq.push_back(6'h05);
    chq.push_back(6'h07);
    chq.push_back(6'h08);
    pulse(3'h5);
    wait_hi(1'h0);
    rd(12'h004, 32'h0001_031B, '1, 2'h0, v);
    pulse(3'h1);
    wait_idle();
    rd(12'h008, 32'h29, '1, 2'h0, v);
    wr(12'h008, 32'h3F);
    $display("test pending done");
    src_t = 1'h0;
    // word 0 now ends a subqueue, so freeze lands on a pausing conversion
    wr(12'h100, 32'h45);
    wr(12'h000, 32'h2003_0022);
    chq.push_back(6'h05);
    pulse(3'h4);
    wait_hi(1'h0);
    freeze <= 1'h1;
    // long enough for the slowest random latency to finish under freeze
    repeat (40) @(posedge clock);
    rd(12'h004, 32'h0002_0024, '1, 2'h0, v);
    pulse(3'h2);
    freeze <= 1'h0;
    pulse(3'h4);
    wait_idle();
    rd(12'h008, 32'h03, '1, 2'h0, v);
    $display("test freeze done");
    complete_run();
  end
endmodule // testbench
